/* hw/area_timing_params.svh */
// Offsets, field positions, reset values and counts for the area timing block.
// Included by the package and by the controller; definitions only.
`ifndef AREA_TIMING_PARAMS_SVH
`define AREA_TIMING_PARAMS_SVH

`define AT_ADDR_W            8
`define AT_DATA_W            16
`define AT_AREAS             5

`define AT_OFF_WAIT_MASK     8'h00
`define AT_OFF_STROBE_TIMING 8'h04
`define AT_OFF_LONG_WAIT     8'h08
`define AT_OFF_AREA_TYPE     8'h0c
`define AT_OFF_WAIT_CODES    8'h10
`define AT_OFF_STATUS        8'h14

`define AT_RST_WAIT_MASK     16'h000b
`define AT_RST_STROBE_TIMING 16'h0000
`define AT_RST_LONG_WAIT     16'heeee
`define AT_RST_AREA_TYPE     16'h00aa
`define AT_RST_WAIT_CODES    16'h0eff
`define AT_WR_WAIT_MASK      16'hdf0f
`define AT_WR_STROBE_TIMING  16'h3bff
`define AT_WR_AREA_TYPE      16'h1fff
`define AT_WR_WAIT_CODES     16'h0fff

`define AT_F_REL_DELAY       15:14
`define AT_F_MASK            12:8
`define AT_F_A4_IDLE         3:2
`define AT_F_A4_WAIT         1:0
`define AT_F_A4_SETUP        13:11
`define AT_F_A4_HOLD         9:8
`define AT_F_SDRAM           12:8
`define AT_F_A4_LONG         11:8

`define AT_LONG_MIN          4'h3
`define AT_LONG_MAX          4'he
`endif

/* hw/area_timing_pkg.sv */
// Types shared by the area timing controller.
// Assumes area_timing_params.svh is on the include path.
`include "area_timing_params.svh"

package area_timing_pkg;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_STROBE = 3'h3,
		ST_RELDLY = 3'h2,
		ST_HOLD   = 3'h6,
		ST_GAP    = 3'h7
	} state_t;

	typedef struct packed {
		state_t                 st;
		logic [3:0]             cnt;
		logic [2:0]             area;
		logic                   wr;
		logic                   sel;
		logic                   addr;
		logic                   stb;
		logic                   done;
		logic [`AT_DATA_W-1:0]  wait_mask;
		logic [`AT_DATA_W-1:0]  strobe_timing;
		logic [`AT_DATA_W-1:0]  long_wait;
		logic [`AT_DATA_W-1:0]  area_type;
		logic [`AT_DATA_W-1:0]  wait_codes;
		logic [`AT_DATA_W-1:0]  rdata;
	} ctrl_t;
endpackage

/* hw/area_wait_setup_hold_ctrl.sv */
// External access timing controller for select areas 0 to 4.
// Assumes synchronous inputs, one clock with both edges used, and a master
// that only requests while acc_ready is high.
//
// Behaviour
// - After area 4 wait release is accepted the strobe negates 1, 2 or 4 cycles later.
// - Reserved bits of both timing registers read as zero and software writes zero.
// - A set wait-mask bit makes its area ignore the external wait input.
// - With the mask clear the wait input counts only when the wait code is not 00.
// - Areas set as synchronous DRAM ignore the wait input entirely.
// - Area 4 inserts at least 0, 1, 2 or 4 idle cycles, two after reset.
// - Area 4 wait code gives no wait, one, two or the long wait.
// - Area 4 strobe follows address and select by 0.5 to 7.5 cycles.
// - Area 4 address hold is 0.5 to 5.5 cycles with select hold 0 to 5.
// - Areas 0 to 3 share one code for setup 0.5 to 2.5 and hold with select 0 to 2.
// - Long wait inserts 3 to 14 wait cycles from the area's long-wait setting.
// - Idle cycles follow the previously accessed area, read followed by write included.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "area_timing_params.svh"

module area_wait_setup_hold_ctrl
	import area_timing_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic [`AT_ADDR_W-1:0] reg_addr,
	input  wire logic [`AT_DATA_W-1:0] reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output logic      [`AT_DATA_W-1:0] reg_rdata,
	input  wire logic                  acc_req,
	input  wire logic [2:0]            acc_area,
	input  wire logic                  acc_write,
	output logic                       acc_ready,
	output logic                       acc_done,
	input  wire logic                  ext_wait_n,
	output logic      [`AT_AREAS-1:0]  area_select_n,
	output logic                       addr_drive,
	output logic                       read_strobe_n,
	output logic                       write_strobe_n
);

	ctrl_t q, d;
	logic  stb_fall_q;
	logic  sel_fall_q;

	// Long waits outside the legal span are pulled back into it
	function automatic logic [3:0] clamp_long(input logic [3:0] v);
		if (v < `AT_LONG_MIN) begin
			return `AT_LONG_MIN;
		end
		if (v > `AT_LONG_MAX) begin
			return `AT_LONG_MAX;
		end
		return v;
	endfunction

	// Whole cycles before the strobe half-step; reserved codes act as the top value
	function automatic logic [3:0] setup_cycles(input ctrl_t s, input logic [2:0] a);
		logic [2:0] c4;
		logic [1:0] cn;
		c4 = s.strobe_timing[`AT_F_A4_SETUP];
		cn = s.strobe_timing[2*a[1:0] +: 2];
		if (a == 3'h4) begin
			unique case (c4)
				3'h0:    return 4'h0;
				3'h1:    return 4'h1;
				3'h2:    return 4'h3;
				3'h3:    return 4'h5;
				default: return 4'h7;
			endcase
		end
		return (cn == 2'h3) ? 4'h2 : {2'h0, cn};
	endfunction

	// Select hold in cycles; address holds half a cycle longer
	function automatic logic [3:0] hold_cycles(input ctrl_t s, input logic [2:0] a);
		logic [1:0] c4;
		logic [1:0] cn;
		c4 = s.strobe_timing[`AT_F_A4_HOLD];
		cn = s.strobe_timing[2*a[1:0] +: 2];
		if (a == 3'h4) begin
			unique case (c4)
				2'h0: return 4'h0;
				2'h1: return 4'h1;
				2'h2: return 4'h3;
				2'h3: return 4'h5;
			endcase
		end
		return (cn == 2'h3) ? 4'h2 : {2'h0, cn};
	endfunction

	function automatic logic [1:0] wait_code(input ctrl_t s, input logic [2:0] a);
		return (a == 3'h4) ? s.wait_mask[`AT_F_A4_WAIT] : s.wait_codes[2*a[1:0] +: 2];
	endfunction

	function automatic logic [3:0] base_waits(input ctrl_t s, input logic [2:0] a);
		logic [3:0] lw;
		lw = (a == 3'h4) ? s.wait_codes[`AT_F_A4_LONG] : s.long_wait[4*a[1:0] +: 4];
		unique case (wait_code(s, a))
			2'h0: return 4'h0;
			2'h1: return 4'h1;
			2'h2: return 4'h2;
			2'h3: return clamp_long(lw);
		endcase
	endfunction

	function automatic logic [3:0] idle_cycles(input ctrl_t s, input logic [2:0] a);
		logic [1:0] c;
		c = (a == 3'h4) ? s.wait_mask[`AT_F_A4_IDLE] : s.area_type[2*a[1:0] +: 2];
		unique case (c)
			2'h0: return 4'h0;
			2'h1: return 4'h1;
			2'h2: return 4'h2;
			2'h3: return 4'h4;
		endcase
	endfunction

	logic                  take;
	logic                  honor_wait;
	logic [3:0]            setup_n;
	logic [3:0]            hold_n;
	logic [3:0]            idle_n;
	logic [1:0]            rel_code;
	logic [4:0]            masks;
	logic [4:0]            sdram;
	logic [`AT_DATA_W-1:0] status;

	assign take      = acc_req && (q.st == ST_IDLE) && (acc_area < 3'h5);
	assign masks     = q.wait_mask[`AT_F_MASK];
	assign sdram     = q.area_type[`AT_F_SDRAM];
	assign rel_code  = q.wait_mask[`AT_F_REL_DELAY];
	assign setup_n   = setup_cycles(q, acc_area);
	assign hold_n    = hold_cycles(q, q.area);
	assign idle_n    = idle_cycles(q, q.area);
	// Wait input only counts if unmasked, enabled by code and not SDRAM
	assign honor_wait = !masks[q.area] && (wait_code(q, q.area) != 2'h0)
		&& !sdram[q.area];
	// Read-only view of the access in flight, for bring-up
	assign status    = {9'h000, q.wr, q.area, q.st};

	always_comb begin
		d      = q;
		d.done = 1'b0;
		unique case (q.st)
			ST_IDLE: begin
				if (take) begin
					d.area = acc_area;
					d.wr   = acc_write;
					d.sel  = 1'b1;
					d.addr = 1'b1;
					if (setup_n == 4'h0) begin
						d.st  = ST_STROBE;
						d.stb = 1'b1;
						d.cnt = base_waits(q, acc_area);
					end else begin
						d.st  = ST_SETUP;
						d.cnt = setup_n - 4'h1;
					end
				end
			end
			ST_SETUP: begin
				if (q.cnt == 4'h0) begin
					d.st  = ST_STROBE;
					d.stb = 1'b1;
					d.cnt = base_waits(q, q.area);
				end else begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			ST_STROBE: begin
				// Base waits run out before the wait line is looked at
				if (q.cnt != 4'h0) begin
					d.cnt = q.cnt - 4'h1;
				end else if (!(honor_wait && !ext_wait_n)) begin
					// Release accepted here
					// Reserved release code stretches like the four-cycle one
					if ((q.area == 3'h4) && (rel_code != 2'h0)) begin
						d.st  = ST_RELDLY;
						d.cnt = (rel_code == 2'h1) ? 4'h0 : 4'h2;
					end else begin
						d.st  = ST_HOLD;
						d.stb = 1'b0;
						d.cnt = hold_n;
						d.sel = (hold_n != 4'h0);
					end
				end
			end
			ST_RELDLY: begin
				if (q.cnt == 4'h0) begin
					d.st  = ST_HOLD;
					d.stb = 1'b0;
					d.cnt = hold_n;
					d.sel = (hold_n != 4'h0);
				end else begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			ST_HOLD: begin
				if (q.cnt == 4'h0) begin
					d.addr = 1'b0;
					d.done = 1'b1;
					// Always idles after the previous area, so read-then-write is covered
					if (idle_n == 4'h0) begin
						d.st = ST_IDLE;
					end else begin
						d.st  = ST_GAP;
						d.cnt = idle_n - 4'h1;
					end
				end else begin
					d.cnt = q.cnt - 4'h1;
					d.sel = (q.cnt != 4'h1);
				end
			end
			ST_GAP: begin
				if (q.cnt == 4'h0) begin
					d.st = ST_IDLE;
				end else begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// Unmapped offsets drop the write
		if (reg_write) begin
			unique case (reg_addr)
				`AT_OFF_WAIT_MASK:     d.wait_mask     = reg_wdata & `AT_WR_WAIT_MASK;
				`AT_OFF_STROBE_TIMING: d.strobe_timing = reg_wdata & `AT_WR_STROBE_TIMING;
				`AT_OFF_LONG_WAIT:     d.long_wait     = reg_wdata;
				`AT_OFF_AREA_TYPE:     d.area_type     = reg_wdata & `AT_WR_AREA_TYPE;
				`AT_OFF_WAIT_CODES:    d.wait_codes    = reg_wdata & `AT_WR_WAIT_CODES;
				default: ;
			endcase
		end

		// Read data stands one cycle only, zero otherwise
		d.rdata = '0;
		if (reg_read) begin
			unique case (reg_addr)
				`AT_OFF_WAIT_MASK:     d.rdata = q.wait_mask;
				`AT_OFF_STROBE_TIMING: d.rdata = q.strobe_timing;
				`AT_OFF_LONG_WAIT:     d.rdata = q.long_wait;
				`AT_OFF_AREA_TYPE:     d.rdata = q.area_type;
				`AT_OFF_WAIT_CODES:    d.rdata = q.wait_codes;
				`AT_OFF_STATUS:        d.rdata = status;
				default:               d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			q               <= '0;
			q.st            <= ST_IDLE;
			q.wait_mask     <= `AT_RST_WAIT_MASK;
			q.strobe_timing <= `AT_RST_STROBE_TIMING;
			q.long_wait     <= `AT_RST_LONG_WAIT;
			q.area_type     <= `AT_RST_AREA_TYPE;
			q.wait_codes    <= `AT_RST_WAIT_CODES;
		end else begin
			q <= d;
		end
	end

	// Falling-edge copies buy the half cycle without a doubled clock
	always_ff @(negedge sys_clk) begin
		if (reset) begin
			stb_fall_q <= 1'b0;
			sel_fall_q <= 1'b0;
		end else begin
			stb_fall_q <= q.stb;
			sel_fall_q <= q.sel;
		end
	end

	assign reg_rdata      = q.rdata;
	assign acc_ready      = (q.st == ST_IDLE);
	assign acc_done       = q.done;
	assign addr_drive     = q.addr;
	assign read_strobe_n  = !(stb_fall_q && !q.wr);
	assign write_strobe_n = !(stb_fall_q && q.wr);

	// Select rises with the address and trails by a half cycle
	always_comb begin
		area_select_n = '1;
		// Per-area compare keeps a stray area code from indexing past the vector
		for (int i = 0; i < `AT_AREAS; i++) begin
			if ((q.sel || sel_fall_q) && (q.area == 3'(i))) begin
				area_select_n[i] = 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

/* verif/ext_mem_model.sv */
// Behavioural external memory that stretches accesses with its wait line.
// Assumes the combined active-low strobe of the controller as input.
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model(
	input  wire logic       sys_clk,
	input  wire logic       strobe_n,
	input  wire logic [3:0] hold_len,
	output logic            ext_wait_n
);
	logic [3:0] left_q;
	always_ff @(posedge sys_clk) begin
		if (strobe_n) begin
			left_q <= hold_len;
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
		end
	end
	// Released outside a strobe, so the pull-up level shows
	assign ext_wait_n = strobe_n || (left_q == 4'h0);
endmodule
`default_nettype wire

/* verif/area_timing_chk.sv */
// Port checker for the area timing controller.
// Bound to the controller; watches its ports only.
`timescale 1ns/1ns
`default_nettype none
`include "area_timing_params.svh"
module area_timing_chk(
	input wire logic                  sys_clk,
	input wire logic                  reset,
	input wire logic [`AT_ADDR_W-1:0] reg_addr,
	input wire logic                  reg_read,
	input wire logic [`AT_DATA_W-1:0] reg_rdata,
	input wire logic                  acc_req,
	input wire logic [2:0]            acc_area,
	input wire logic                  acc_ready,
	input wire logic                  acc_done,
	input wire logic [`AT_AREAS-1:0]  area_select_n,
	input wire logic                  addr_drive,
	input wire logic                  read_strobe_n,
	input wire logic                  write_strobe_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire stb_n = read_strobe_n & write_strobe_n;
	a_mask_rsvd_zero: assert property ($past(reg_read) && $past(reg_addr) == 8'h00
		|-> (reg_rdata & 16'h20f0) == 16'h0000) else $error("reserved mask bits set");
	a_strb_rsvd_zero: assert property ($past(reg_read) && $past(reg_addr) == 8'h04
		|-> (reg_rdata & 16'hc400) == 16'h0000) else $error("reserved timing bits set");
	a_strobe_in_select: assert property (!stb_n |-> addr_drive && area_select_n != 5'h1f)
		else $error("strobe outside select");
	a_addr_hold: assert property ($rose(stb_n) |-> addr_drive)
		else $error("address dropped with strobe");
	a_done_pulse: assert property (acc_done |=> !acc_done)
		else $error("done longer than one cycle");
	a_done_released: assert property (acc_done |-> area_select_n == 5'h1f && stb_n)
		else $error("done before release");
	a_busy_not_ready: assert property (!stb_n |-> !acc_ready)
		else $error("ready during strobe");
	a_take_select: assert property (acc_req && acc_ready && acc_area < 3'h5
		|=> area_select_n == ~(5'h01 << $past(acc_area))) else $error("wrong select");
endmodule
bind area_wait_setup_hold_ctrl area_timing_chk u_chk(.sys_clk(sys_clk), .reset(reset),
	.reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .acc_req(acc_req),
	.acc_area(acc_area), .acc_ready(acc_ready), .acc_done(acc_done),
	.area_select_n(area_select_n), .addr_drive(addr_drive),
	.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
`default_nettype wire

/* verif/area_wait_setup_hold_ctrl_tb.sv */
// Self-checking bench for the area timing controller.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
`include "area_timing_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %0t: got %0h want %0h", $time, g, e); end end
module area_wait_setup_hold_ctrl_tb;
	logic        sys_clk, reset, reg_write, reg_read, acc_req, acc_write;
	logic        acc_ready, acc_done, ext_wait_n, addr_drive, read_strobe_n, write_strobe_n;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [2:0]  acc_area;
	logic [4:0]  area_select_n;
	logic [3:0]  wait_len;
	logic        sw;
	int          err_total, check_count, cyc, t0, t1, t2, t3, gap, wb;
	int          stp[5] = '{50, 150, 350, 550, 750};
	int          hld[4] = '{0, 100, 300, 500};
	int          idl[4] = '{0, 1, 2, 4};
	int          rel[3] = '{1, 2, 4};
	wire         stb_n = read_strobe_n & write_strobe_n;
	wire         sel_n = &area_select_n;
	area_wait_setup_hold_ctrl i_dut(.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .acc_req(acc_req), .acc_area(acc_area),
		.acc_write(acc_write), .acc_ready(acc_ready), .acc_done(acc_done),
		.ext_wait_n(ext_wait_n), .area_select_n(area_select_n), .addr_drive(addr_drive),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
	ext_mem_model i_mem(.sys_clk(sys_clk), .strobe_n(stb_n), .hold_len(wait_len),
		.ext_wait_n(ext_wait_n));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Edge times in ns give the half-cycle setup and hold directly
	always @(negedge sel_n) t0 = $time;
	// Which strobe fell tells read from write
	always @(negedge stb_n) begin
		t1 = $time;
		sw = read_strobe_n;
	end
	always @(posedge stb_n) t2 = $time;
	always @(posedge sel_n) t3 = $time;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			finish_test();
		end
	end
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	// One access; leaves gap as the idle cycles seen after done
	task acc(input logic [2:0] a, input logic w, input logic [3:0] wl);
		int n;
		@(posedge sys_clk);
		acc_req <= 1'b1;
		acc_area <= a;
		acc_write <= w;
		wait_len <= wl;
		@(posedge sys_clk);
		acc_req <= 1'b0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1 n++;
		end while (acc_done !== 1'b1 && n < 100);
		if (n >= 100) begin
			err_total++;
			$display("unexpected %0t: no done", $time);
		end
		`CHK(sw, w)
		gap = 0;
		while (acc_ready !== 1'b1 && gap < 20) begin
			@(posedge sys_clk);
			#1 gap++;
		end
		if (gap >= 20) begin
			err_total++;
			$display("unexpected %0t: no ready", $time);
		end
	endtask
	initial begin
		{reset, reg_write, reg_read, acc_req, acc_write} = 5'b10000;
		{reg_addr, reg_wdata, acc_area, wait_len} = '0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		rd(8'h00, 16'h000b);
		rd(8'h04, 16'h0000);
		rd(`AT_OFF_LONG_WAIT, 16'heeee);
		rd(`AT_OFF_AREA_TYPE, 16'h00aa);
		rd(`AT_OFF_WAIT_CODES, 16'h0eff);
		rd(`AT_OFF_STATUS, 16'h0000);
		// Software keeps reserved bits and reserved codes at zero
		wr(8'h00, 16'h9f0f);
		rd(8'h00, 16'h9f0f);
		wr(8'h04, 16'h23aa);
		rd(8'h04, 16'h23aa);
		rd(8'h20, 16'h0000);
		$display("registers done");
		wr(8'h00, 16'h0000);
		wr(`AT_OFF_WAIT_CODES, 16'h0000);
		wr(`AT_OFF_AREA_TYPE, 16'h0000);
		for (int c = 0; c < 3; c++) begin
			wr(8'h04, 16'(16'h0055 * c));
			acc(3'(c), c[0], 4'h0);
			`CHK(t1 - t0, c * 100 + 50)
			`CHK(t3 - t2, c * 100)
		end
		for (int k = 0; k < 5; k++) begin
			wr(8'h04, 16'((k << 11) | ((k % 4) << 8)));
			acc(3'h4, k[0], 4'h5);
			`CHK(t1 - t0, stp[k])
			`CHK(t3 - t2, hld[k % 4])
			`CHK(t2 - t1, 100)
		end
		$display("setup and hold done");
		wr(8'h04, 16'h0000);
		for (int w = 1; w < 4; w++) begin
			wr(8'h00, 16'(16'h1000 | w));
			acc(3'h4, 1'b0, 4'h8);
			`CHK(t2 - t1, (w + 1) * 100)
		end
		wr(`AT_OFF_WAIT_CODES, 16'h0f00);
		acc(3'h4, 1'b1, 4'h0);
		`CHK(t2 - t1, 1500)
		for (int d = 0; d < 3; d++) begin
			wr(8'h00, 16'((d << 14) | 1));
			acc(3'h4, 1'b1, 4'h6);
			if (d == 0)
				wb = t2 - t1;
			`CHK(t2 - t1 - wb, (rel[d] - 1) * 100)
		end
		`CHK(wb > 200, 1'b1)
		wr(`AT_OFF_WAIT_CODES, 16'h0001);
		wr(`AT_OFF_AREA_TYPE, 16'h0100);
		acc(3'h0, 1'b0, 4'h6);
		`CHK(t2 - t1, 200)
		$display("waits done");
		wr(`AT_OFF_WAIT_CODES, 16'h0000);
		wr(`AT_OFF_AREA_TYPE, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, 16'(i << 2));
			acc(3'h4, i[0], 4'h0);
			`CHK(gap >= idl[i], 1'b1)
		end
		wr(`AT_OFF_AREA_TYPE, 16'h0003);
		wr(8'h00, 16'h0000);
		acc(3'h0, 1'b0, 4'h0);
		`CHK(gap >= 4, 1'b1)
		acc(3'h0, 1'b1, 4'h0);
		`CHK(gap >= 4, 1'b1)
		$display("idle done");
		finish_test();
	end
endmodule
`default_nettype wire
